// ---- dv/testbench.sv ----
//
// Purpose: self-checking bench of the async serial port
// Assumes: remote end model drives the receive line
// Notes:   expected values come from a small model in the bench
//
`timescale 1ns/1ps
module testbench
    import uasp_pkg::*;
;
    logic       clock_i   = 1'b0;
    logic       rstn_i    = 1'b0;
    uasp_bus_t  bus       = '0;
    logic [7:0] rdata;
    logic       rxd;
    logic       txd;
    logic       tirq;
    logic       rirq;
    logic       tflag;
    int         err_count = 0;
    int         compares  = 0;
    int         m_buf     = 0;
    int         m_stat    = 0;
    int         m_unread  = 0;

    always #10 clock_i = ~clock_i;

    uasp_top dut (
        .clock_i                 (clock_i),
        .rstn_i                  (rstn_i),
        .bus_i                   (bus),
        .rdata_o                 (rdata),
        .receive_line_i          (rxd),
        .txd_o                   (txd),
        .transmit_complete_irq_o (tirq),
        .receive_complete_irq_o  (rirq),
        .transmit_complete_flag_o(tflag)
    );
    uasp_remote remote (.clock_i(clock_i), .txd_i(txd), .rxd_o(rxd));

    // ----------------------------------------
    // compare, report and bus tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic conclude();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rc(input logic [15:0] a, input logic [7:0] e, input string nm);
        @(posedge clock_i);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        bus.rd <= 1'b0;
        #1 chk(nm, 12'(e), 12'(rdata));
    endtask : rc

    task automatic expect_ev(input bit tx, input int lim);
        bit seen;
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge clock_i);
            seen = tx ? (tirq === 1'b1) : (rirq === 1'b1);
        end
        chk(tx ? "tx event" : "rx event", 12'h1, 12'(seen));
        if (!seen) conclude();
    endtask : expect_ev

    task automatic quiet(input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(posedge clock_i);
            bad = bad | (tirq !== 1'b0) | (rirq !== 1'b0) | (txd !== 1'b1);
        end
        chk("quiet", 12'h0, 12'(bad));
    endtask : quiet

    function automatic logic par(input logic [7:0] d, input int pm);
        return (pm == 3) ? ^d : ((pm == 2) ? ~^d : 1'b0);
    endfunction : par

    task automatic setup(input int sel, input logic [7:0] mode);
        wr(UASP_ADDR_BSEL, 8'(sel << 4));
        remote.bit_clks = 32 << sel;
        wr(UASP_ADDR_AMODE, mode);
    endtask : setup

    // ----------------------------------------
    // one frame each way, with model update
    // ----------------------------------------
    task automatic tx_frame(input logic [7:0] d, input int pm, input bit cl, input bit sl);
        logic [11:0] v;
        logic [11:0] e;
        int          nb;
        int          hp;
        bit          ok;
        nb = cl ? 8 : 7;
        hp = (pm != 0) ? 1 : 0;
        e = 12'(cl ? d : d & 8'h7f);
        if (hp == 1) e[nb] = par(e[7:0], pm);
        e[nb + hp] = 1'b1;
        if (sl) e[nb + hp + 1] = 1'b1;
        fork
            wr(UASP_ADDR_DATA, d);
            remote.recv(nb + hp + 1 + int'(sl), v, ok);
        join
        chk("tx frame", e, ok ? v : 12'hfff);
        if (!ok) conclude();
        expect_ev(1'b1, 2 * remote.bit_clks + 10);
        chk("tx flag", 12'h1, 12'(tflag));
        rc(UASP_ADDR_TFLAG, 8'h01, "tx flag read");
        chk("tx flag clear", 12'h0, 12'(tflag));
    endtask : tx_frame

    task automatic rx_frame(input logic [7:0] d, input int pm, input bit cl,
                            input bit bad, input bit stp);
        logic [11:0] v;
        int          nb;
        int          hp;
        nb = cl ? 8 : 7;
        hp = (pm != 0) ? 1 : 0;
        v = 12'(cl ? d : d & 8'h7f);
        if (hp == 1) v[nb] = par(v[7:0], pm) ^ bad;
        v[nb + hp] = stp;
        fork
            remote.send(v, nb + hp + 1);
            expect_ev(1'b0, 14 * remote.bit_clks);
        join
        m_stat = ((bad && pm >= 2) ? 4 : 0) | (stp ? 0 : 2) | m_unread;
        m_buf = int'(v[7:0]) & (cl ? 255 : 127);
        m_unread = 1;
    endtask : rx_frame

    task automatic rx_check();
        rc(UASP_ADDR_ESTAT, 8'(m_stat), "status");
        rc(UASP_ADDR_DATA, 8'(m_buf), "buffer");
        m_stat = 0;
        m_unread = 0;
    endtask : rx_check

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        bit sl;
        void'($urandom(32'h1e711484));
        repeat (16) @(posedge clock_i);
        rstn_i <= 1'b1;
        for (int a = 0; a < 7; a++) begin
            rc(16'hff70 + 16'(a), 8'h00, "reset value");
        end
        wr(UASP_ADDR_CMODE, 8'h86);
        rc(UASP_ADDR_CMODE, 8'h86, "clocked mode");
        wr(UASP_ADDR_AMODE, 8'hfc);
        rc(UASP_ADDR_AMODE, 8'hfc, "async mode");
        setup(0, 8'h00);
        wr(UASP_ADDR_DATA, 8'h55);
        quiet(300);
        for (int i = 0; i < 8; i++) begin
            sl = 1'($urandom);
            setup(i % 2, 8'h80 | (8'(i >> 1) << 4) | (8'(i & 1) << 3) | (8'(sl) << 2));
            tx_frame(8'($urandom), i >> 1, 1'(i & 1), sl);
        end
        setup(0, 8'h80);
        wr(UASP_ADDR_DATA, 8'h00);
        repeat (100) @(posedge clock_i);
        wr(UASP_ADDR_AMODE, 8'h00);
        @(posedge clock_i);
        quiet(50);
        wr(UASP_ADDR_DATA, 8'hff);
        setup(0, 8'h88);
        tx_frame(8'($urandom), 0, 1'b1, 1'b0);
        setup(0, 8'h78);
        remote.glitch(8);
        quiet(100);
        for (int i = 0; i < 16; i++) begin
            setup(i % 2, 8'h40 | (8'((i >> 1) & 3) << 4) | (8'(i & 1) << 3)
                         | (8'(i >> 3) << 2));
            rx_frame(8'($urandom), (i >> 1) & 3, 1'(i & 1), 1'(i >> 3), 1'b1);
            rx_check();
        end
        setup(0, 8'h48);
        rx_frame(8'($urandom), 0, 1'b1, 1'b0, 1'b0);
        rx_check();
        rx_frame(8'($urandom), 0, 1'b1, 1'b0, 1'b1);
        rx_frame(8'($urandom), 0, 1'b1, 1'b0, 1'b1);
        rx_check();
        rc(UASP_ADDR_ESTAT, 8'h00, "status cleared");
        fork
            remote.send(12'h1a5, 9);
            begin
                repeat (160) @(posedge clock_i);
                wr(UASP_ADDR_AMODE, 8'h08);
                quiet(200);
            end
        join
        rx_check();
        conclude();
    end
endmodule : testbench

// ---- dv/uasp_remote.sv ----
//
// Purpose: remote serial end that sends frames and captures frames
// Assumes: bit length in system clocks is set by the bench
// Notes:   line held high whenever no frame or glitch is sent
//
`timescale 1ns/1ps
module uasp_remote (
    // clock
    input  wire logic clock_i,
    // serial lines
    input  wire logic txd_i,
    output logic      rxd_o
);
    int bit_clks = 32;

    initial rxd_o = 1'b1;

    // ----------------------------------------
    // send start bit, n bits lsb first, idle
    // ----------------------------------------
    task automatic send(input logic [11:0] v, input int n);
        rxd_o <= 1'b0;
        repeat (bit_clks) @(posedge clock_i);
        for (int i = 0; i < n; i++) begin
            rxd_o <= v[i];
            repeat (bit_clks) @(posedge clock_i);
        end
        rxd_o <= 1'b1;
        repeat (bit_clks) @(posedge clock_i);
    endtask : send

    task automatic glitch(input int n);
        rxd_o <= 1'b0;
        repeat (n) @(posedge clock_i);
        rxd_o <= 1'b1;
    endtask : glitch

    // ----------------------------------------
    // capture n bits after a start bit
    // ----------------------------------------
    task automatic recv(input int n, output logic [11:0] v, output bit ok);
        int t;
        v = '0;
        t = 0;
        while (txd_i !== 1'b0 && t < 2000) begin
            @(posedge clock_i);
            t++;
        end
        ok = (t < 2000);
        repeat (bit_clks / 2) @(posedge clock_i);
        for (int i = 0; i < n; i++) begin
            repeat (bit_clks) @(posedge clock_i);
            v[i] = txd_i;
        end
    endtask : recv
endmodule : uasp_remote

// ---- logic/uasp_baud.sv ----
//
// Purpose: baud tick generator, one tick per eighth of a bit
// Assumes: selection field 0..7, other codes stop the ticks
// Notes:   tick period is 2^(sel+2) system clocks
//
`timescale 1ns/1ps
module uasp_baud
    import uasp_pkg::*;
(
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    // selection
    input  wire logic [3:0] sel_i,
    // tick
    output logic            tick_o
);

    typedef struct packed {
        logic [8:0] cnt;
        logic       tick;
    } uasp_baud_st_t;

    uasp_baud_st_t s_r;
    uasp_baud_st_t s_nxt;

    function automatic logic [8:0] div_last(input logic [3:0] sel);
        logic [9:0] span;
        span = 10'h001 << (sel + 4'h2);
        return 9'(span - 10'h001);
    endfunction : div_last

    // ----------------------------------------
    // prescaler
    // ----------------------------------------
    always_comb begin
        s_nxt      = s_r;
        s_nxt.tick = 1'b0;
        if (sel_i > UASP_TPS_MAX) begin
            s_nxt.cnt = '0;
        end else if (s_r.cnt >= div_last(sel_i)) begin
            s_nxt.cnt  = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 9'h001;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick_o = s_r.tick;

endmodule : uasp_baud

// ---- logic/uasp_top.sv ----
//
// Purpose: asynchronous serial transmit and receive port
// Assumes: byte register port, 50 MHz system clock
// Notes:   clocked 3-wire mode register is held but does not shift
//
// Summary of operation
// - odd parity: even ones count is error
// - zero parity: send 0, never check
// - no parity: no bit sent, none expected
// - data write starts framed transmission
// - shift register empty raises transmit interrupt, flag
// - receive enable bit 6 starts line sampling
// - low line, half bit recheck, start
// - frame ends after one stop bit
// - frame end loads buffer, raises receive interrupt
// - errored frames still load and interrupt
// - clearing receive enable aborts, nothing changes
// - status bits parity 04, framing 02, overrun 01
// - framing no stop; overrun unread buffer
// - buffer read or next frame clears status
// - unread buffer keeps causing overrun
// - late disable outcome depends on timing
// - clocked mode register resets zero, bits 7,2,1
// - even parity generation and checking
// - odd parity generation
// - mode register fields at its address
// - seven bit mode drops bit 7
//
`timescale 1ns/1ps
module uasp_top
    import uasp_pkg::*;
(
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    // register port
    input  wire uasp_bus_t  bus_i,
    output logic [7:0]      rdata_o,
    // serial line
    input  wire logic       receive_line_i,
    output logic            txd_o,
    // events
    output logic            transmit_complete_irq_o,
    output logic            receive_complete_irq_o,
    output logic            transmit_complete_flag_o
);

    typedef struct packed {
        logic [7:0]  amode;
        logic [7:0]  cmode;
        logic [7:0]  bsel;
        logic [7:0]  rbuf;
        logic [2:0]  err;
        logic        unread;
        logic        tflag;
        uasp_tx_st_t tx_st;
        logic [2:0]  tcnt;
        logic [3:0]  tbits;
        logic [7:0]  tsh;
        logic        tpar;
        logic        tstop2;
        logic        txd;
        uasp_rx_st_t rx_st;
        logic [2:0]  rcnt;
        logic [3:0]  rbits;
        logic [7:0]  rsh;
        logic        rpar;
        logic [2:0]  rsync;
        logic        rxl;
        logic [7:0]  rdata;
        logic        tirq;
        logic        rirq;
    } uasp_state_t;

    uasp_state_t s_r;
    uasp_state_t s_nxt;
    logic        tick;
    logic        txe;
    logic        rxe;
    logic [1:0]  pmode;
    logic        char8;
    logic [3:0]  bits_last;
    logic [7:0]  wdat;
    logic [7:0]  rx_word;
    logic        frame_done;

    uasp_baud u_baud (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .sel_i   (s_r.bsel[UASP_TPS_HI:UASP_TPS_LO]),
        .tick_o  (tick)
    );

    assign txe       = s_r.amode[UASP_TXE_BIT];
    assign rxe       = s_r.amode[UASP_RXE_BIT];
    assign pmode     = s_r.amode[UASP_PS_HI:UASP_PS_LO];
    assign char8     = s_r.amode[UASP_CL_BIT];
    assign bits_last = char8 ? UASP_BITS8 : UASP_BITS7;
    assign wdat      = char8 ? bus_i.wdata : (bus_i.wdata & UASP_MSB_MSK);

    always_comb begin
        s_nxt      = s_r;
        s_nxt.tirq = 1'b0;
        s_nxt.rirq = 1'b0;
        rx_word    = '0;
        frame_done = 1'b0;

        // ----------------------------------------
        // pin synchroniser, three stages
        // ----------------------------------------
        s_nxt.rsync = {s_r.rsync[1:0], receive_line_i};
        if (s_r.rsync[1] == s_r.rsync[2]) begin
            s_nxt.rxl = s_r.rsync[2];
        end

        // ----------------------------------------
        // register reads
        // ----------------------------------------
        s_nxt.rdata = '0;
        if (bus_i.rd) begin
            case (bus_i.addr)
                UASP_ADDR_AMODE: s_nxt.rdata = s_r.amode;
                UASP_ADDR_ESTAT: s_nxt.rdata = {5'h00, s_r.err};
                UASP_ADDR_CMODE: s_nxt.rdata = s_r.cmode;
                UASP_ADDR_BSEL:  s_nxt.rdata = s_r.bsel;
                UASP_ADDR_TFLAG: s_nxt.rdata = {7'h00, s_r.tflag};
                UASP_ADDR_DATA: begin
                    s_nxt.rdata  = s_r.rbuf;
                    s_nxt.err    = '0;
                    s_nxt.unread = 1'b0;
                end
                default:         s_nxt.rdata = '0;
            endcase
            if (bus_i.addr == UASP_ADDR_TFLAG) begin
                s_nxt.tflag = 1'b0;
            end
        end

        // ----------------------------------------
        // register writes
        // ----------------------------------------
        if (bus_i.wr) begin
            case (bus_i.addr)
                UASP_ADDR_AMODE: s_nxt.amode = bus_i.wdata & UASP_AMODE_MSK;
                UASP_ADDR_CMODE: s_nxt.cmode = bus_i.wdata & UASP_CMODE_MSK;
                UASP_ADDR_BSEL:  s_nxt.bsel  = bus_i.wdata & UASP_BSEL_MSK;
                UASP_ADDR_DATA: begin
                    if (txe && s_r.tx_st == TX_IDLE) begin
                        s_nxt.tsh   = wdat;
                        s_nxt.tx_st = TX_START;
                        s_nxt.txd   = 1'b0;
                        s_nxt.tcnt  = '0;
                        s_nxt.tpar  = (pmode == UASP_PAR_EVEN) ? uasp_ones_odd(wdat)
                                    : (pmode == UASP_PAR_ODD) ? ~uasp_ones_odd(wdat)
                                    : 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // ----------------------------------------
        // transmitter
        // ----------------------------------------
        if (!txe) begin
            s_nxt.tx_st = TX_IDLE;
            s_nxt.txd   = 1'b1;
        end else if (tick && s_r.tx_st != TX_IDLE) begin
            s_nxt.tcnt = s_r.tcnt + 3'h1;
            if (s_r.tcnt == UASP_TICK_LAST) begin
                case (s_r.tx_st)
                    TX_START: begin
                        s_nxt.tx_st = TX_DATA;
                        s_nxt.tbits = '0;
                        s_nxt.txd   = s_r.tsh[0];
                    end
                    TX_DATA: begin
                        s_nxt.tsh   = s_r.tsh >> 1;
                        s_nxt.tbits = s_r.tbits + 4'h1;
                        if (s_r.tbits != bits_last) begin
                            s_nxt.txd = s_r.tsh[1];
                        end else if (pmode == UASP_PAR_NONE) begin
                            s_nxt.tx_st  = TX_STOP;
                            s_nxt.txd    = 1'b1;
                            s_nxt.tstop2 = s_r.amode[UASP_SL_BIT];
                        end else begin
                            s_nxt.tx_st = TX_PAR;
                            s_nxt.txd   = s_r.tpar;
                        end
                    end
                    TX_PAR: begin
                        s_nxt.tx_st  = TX_STOP;
                        s_nxt.txd    = 1'b1;
                        s_nxt.tstop2 = s_r.amode[UASP_SL_BIT];
                    end
                    TX_STOP: begin
                        if (s_r.tstop2) begin
                            s_nxt.tstop2 = 1'b0;
                        end else begin
                            s_nxt.tx_st = TX_IDLE;
                            s_nxt.tirq  = 1'b1;
                            s_nxt.tflag = 1'b1;
                        end
                    end
                    default: s_nxt.tx_st = TX_IDLE;
                endcase
            end
        end

        // ----------------------------------------
        // receiver
        // ----------------------------------------
        if (!rxe) begin
            s_nxt.rx_st = RX_IDLE;
        end else begin
            case (s_r.rx_st)
                RX_IDLE: begin
                    if (s_r.rxl && !s_nxt.rxl) begin
                        s_nxt.rx_st = RX_START;
                        s_nxt.rcnt  = '0;
                    end
                end
                RX_START: begin
                    if (tick) begin
                        s_nxt.rcnt = s_r.rcnt + 3'h1;
                        if (s_r.rcnt == UASP_HALF_LAST) begin
                            s_nxt.rx_st = s_r.rxl ? RX_IDLE : RX_DATA;
                            s_nxt.rcnt  = '0;
                            s_nxt.rbits = '0;
                        end
                    end
                end
                RX_DATA, RX_PAR, RX_STOP: begin
                    if (tick) begin
                        s_nxt.rcnt = s_r.rcnt + 3'h1;
                        if (s_r.rcnt == UASP_TICK_LAST) begin
                            if (s_r.rx_st == RX_DATA) begin
                                s_nxt.rsh   = {s_r.rxl, s_r.rsh[7:1]};
                                s_nxt.rbits = s_r.rbits + 4'h1;
                                if (s_r.rbits == bits_last) begin
                                    s_nxt.rx_st = (pmode == UASP_PAR_NONE) ? RX_STOP
                                                                          : RX_PAR;
                                    if (!char8) begin
                                        s_nxt.rsh = {1'b0, s_r.rxl, s_r.rsh[7:2]};
                                    end
                                end
                            end else if (s_r.rx_st == RX_PAR) begin
                                s_nxt.rpar  = s_r.rxl;
                                s_nxt.rx_st = RX_STOP;
                            end else begin
                                frame_done  = 1'b1;
                                s_nxt.rx_st = RX_IDLE;
                            end
                        end
                    end
                end
                default: s_nxt.rx_st = RX_IDLE;
            endcase
        end

        // ----------------------------------------
        // frame completion, set wins over read
        // ----------------------------------------
        if (frame_done) begin
            rx_word                 = s_r.rsh;
            s_nxt.rbuf              = rx_word;
            s_nxt.rirq              = 1'b1;
            s_nxt.err               = '0;
            s_nxt.err[UASP_ERR_FRM] = !s_r.rxl;
            s_nxt.err[UASP_ERR_OVR] = s_r.unread;
            case (pmode)
                UASP_PAR_ODD:  s_nxt.err[UASP_ERR_PAR] = !(uasp_ones_odd(rx_word) ^ s_r.rpar);
                UASP_PAR_EVEN: s_nxt.err[UASP_ERR_PAR] = uasp_ones_odd(rx_word) ^ s_r.rpar;
                default:       s_nxt.err[UASP_ERR_PAR] = 1'b0;
            endcase
            s_nxt.unread            = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r       <= '0;
            s_r.txd   <= 1'b1;
            s_r.rxl   <= 1'b1;
            s_r.rsync <= 3'h7;
            s_r.cmode <= UASP_RST_BYTE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata_o                  = s_r.rdata;
    assign txd_o                    = s_r.txd;
    assign transmit_complete_irq_o  = s_r.tirq;
    assign receive_complete_irq_o   = s_r.rirq;
    assign transmit_complete_flag_o = s_r.tflag;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    a_tx_idle_high: assert property (s_r.tx_st == TX_IDLE |-> txd_o)
        else $error("transmit line low while idle");
    a_zero_par_bit: assert property ((s_r.tx_st == TX_PAR && pmode == UASP_PAR_ZERO)
                                     |-> !txd_o)
        else $error("zero parity bit sent as one");
    a_tx_done_irq: assert property (transmit_complete_irq_o
                                    |-> $past(s_r.tx_st) == TX_STOP && transmit_complete_flag_o)
        else $error("transmit interrupt without stop bit end");
    a_start_frame: assert property ((bus_i.wr && bus_i.addr == UASP_ADDR_DATA && txe
                                     && s_r.tx_st == TX_IDLE) |=> s_r.tx_st == TX_START && !txd_o)
        else $error("data write did not start frame");
    a_rx_abort: assert property (!rxe
                                 |=> s_r.rx_st == RX_IDLE && !receive_complete_irq_o)
        else $error("reception continued after disable");
    a_no_par_err: assert property ((receive_complete_irq_o && !pmode[1])
                                   |-> !s_r.err[UASP_ERR_PAR])
        else $error("parity error without parity check");
    a_seven_msb: assert property ((receive_complete_irq_o && !char8) |-> !s_r.rbuf[7])
        else $error("seven bit data has bit 7 set");
    a_ovr_flag: assert property (receive_complete_irq_o
                                 |-> s_r.err[UASP_ERR_OVR] == $past(s_r.unread))
        else $error("overrun flag wrong");
    a_stat_clear: assert property ((bus_i.rd && bus_i.addr == UASP_ADDR_DATA && !frame_done)
                                   |=> s_r.err == 3'h0 && !s_r.unread
                                       && rdata_o == $past(s_r.rbuf))
        else $error("status not cleared by buffer read");

endmodule : uasp_top

// ---- shared/uasp_pkg.sv ----
//
// Purpose: constants, types and state encodings of the async serial port
// Assumes: byte-wide register port, one system clock
// Notes:   shared by the port logic and its baud tick generator
//
package uasp_pkg;

    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [15:0] UASP_ADDR_AMODE = 16'hff70;
    localparam logic [15:0] UASP_ADDR_ESTAT = 16'hff71;
    localparam logic [15:0] UASP_ADDR_CMODE = 16'hff72;
    localparam logic [15:0] UASP_ADDR_BSEL  = 16'hff73;
    localparam logic [15:0] UASP_ADDR_DATA  = 16'hff74;
    localparam logic [15:0] UASP_ADDR_TFLAG = 16'hff75;

    // ----------------------------------------
    // field layouts and reset values
    // ----------------------------------------
    localparam int          UASP_TXE_BIT   = 7;
    localparam int          UASP_RXE_BIT   = 6;
    localparam int          UASP_PS_HI     = 5;
    localparam int          UASP_PS_LO     = 4;
    localparam int          UASP_CL_BIT    = 3;
    localparam int          UASP_SL_BIT    = 2;
    localparam int          UASP_TPS_HI    = 7;
    localparam int          UASP_TPS_LO    = 4;
    localparam int          UASP_ERR_PAR   = 2;
    localparam int          UASP_ERR_FRM   = 1;
    localparam int          UASP_ERR_OVR   = 0;
    localparam logic [7:0]  UASP_AMODE_MSK = 8'hfc;
    localparam logic [7:0]  UASP_CMODE_MSK = 8'h86;
    localparam logic [7:0]  UASP_BSEL_MSK  = 8'hf0;
    localparam logic [7:0]  UASP_RST_BYTE  = 8'h00;
    localparam logic [7:0]  UASP_MSB_MSK   = 8'h7f;
    localparam logic [3:0]  UASP_TPS_MAX   = 4'h7;

    // ----------------------------------------
    // parity modes
    // ----------------------------------------
    localparam logic [1:0]  UASP_PAR_NONE = 2'h0;
    localparam logic [1:0]  UASP_PAR_ZERO = 2'h1;
    localparam logic [1:0]  UASP_PAR_ODD  = 2'h2;
    localparam logic [1:0]  UASP_PAR_EVEN = 2'h3;

    // ----------------------------------------
    // timing: eight ticks per bit, 3-bit counter
    // ----------------------------------------
    localparam logic [2:0]  UASP_TICK_LAST = 3'h7;
    localparam logic [2:0]  UASP_HALF_LAST = 3'h3;
    localparam logic [3:0]  UASP_BITS7     = 4'h6;
    localparam logic [3:0]  UASP_BITS8     = 4'h7;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } uasp_bus_t;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uasp_tx_st_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uasp_rx_st_t;

    function automatic logic uasp_ones_odd(input logic [7:0] d);
        return ^d;
    endfunction : uasp_ones_odd

endpackage : uasp_pkg
